// *** include/scca_map.svh ***
`ifndef SCCA_MAP_SVH
`define SCCA_MAP_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define SCCA_CHAR_W 8
`define SCCA_STAT_W 4
`define SCCA_BUF_W 12

// ----------------------------------------------------------------
// reset and load values
// ----------------------------------------------------------------
`define SCCA_CHAR_CLR 8'h00
`define SCCA_BUF_CLR 12'h000
`define SCCA_STAT_RSVD 2'h0
`define SCCA_CTR_TOP 8'h80
`define SCCA_CTR_LAST 8'h40

// ----------------------------------------------------------------
// ones-run positions (thermometer of consecutive ones)
// ----------------------------------------------------------------
`define SCCA_RUN_STUFF 4
`define SCCA_RUN_FLAG 5

// ----------------------------------------------------------------
// status bit positions within the buffer status nibble
// ----------------------------------------------------------------
`define SCCA_ST_CRC 0
`define SCCA_ST_END 1

`endif

// *** include/scca_pkg.sv ***
package scca_pkg;

    // receive control state; framed is every state but SCCA_INACT
    typedef enum logic [1:0] {
        SCCA_INACT = 2'b00,
        SCCA_ADDR = 2'b01,
        SCCA_ACTIVE = 2'b10,
        SCCA_WAIT = 2'b11
    } scca_rcs_e;

endpackage

// *** test/scca_modem.sv ***
`timescale 1ns/1ns

module scca_modem (
    // link toward the receiver
    output logic rx_clk,
    output logic rx_data
);
    int ones = 0;
    int slow = 0;

    // clock stands low outside frames, line idles marking
    initial begin
        rx_clk = 1'b0;
        rx_data = 1'b1;
    end

    // data moves while the clock is low; sampled on the rise
    task automatic send_bit(input logic b);
        rx_data = b;
        #(7 + slow);
        rx_clk = 1'b1;
        #(8 + slow);
        rx_clk = 1'b0;
        ones = b ? ones + 1 : 0;
    endtask

    task automatic send_byte(input logic [7:0] v, input bit stuff);
        for (int i = 0; i < 8; i++) begin
            send_bit(v[i]);
            if (stuff && ones == 5) begin
                send_bit(1'b0);
            end
        end
    endtask

    task automatic send_flag();
        send_byte(8'h7E, 1'b0);
    endtask

    task automatic idle();
        rx_data = 1'b1;
        #40;
    endtask
endmodule

// *** test/scca_monitor.sv ***
`timescale 1ns/1ns

module scca_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // link and controls
    input wire logic rx_clk,
    input wire logic receiver_reset_line,
    input wire logic crc_ok,
    // observed outputs
    input wire logic [7:0] first_shift_reg,
    input wire logic char_complete,
    input wire logic crc_bit,
    input wire logic crc_strobe,
    input wire logic [11:0] rx_buffer,
    input wire logic rx_buffer_load
);
    // cycles since the last completion, saturating so a stale one never counts
    logic [3:0] since_cc;
    logic [3:0] next_since_cc;

    always_comb begin
        next_since_cc = since_cc;
        if (char_complete) begin
            next_since_cc = 4'h0;
        end else if (since_cc != 4'hF) begin
            next_since_cc = since_cc + 4'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            since_cc <= 4'hF;
        end else begin
            since_cc <= next_since_cc;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_rsvd_zero: assert property (rx_buffer[11:10] == 2'h0)
        else $error("reserved status bits set");
    a_cc_pulse: assert property (char_complete |=> !char_complete)
        else $error("completion longer than one cycle");
    a_strobe_pulse: assert property (crc_strobe |=> !crc_strobe)
        else $error("shift strobe longer than one cycle");
    a_load_pulse: assert property (rx_buffer_load |=> !rx_buffer_load)
        else $error("load longer than one cycle");
    a_shift_moves: assert property (crc_strobe && !$past(receiver_reset_line) |->
        first_shift_reg[6:0] == $past(first_shift_reg[7:1]) && crc_bit == $past(first_shift_reg[0]))
        else $error("shift register did not shift");
    a_reg_holds: assert property (!crc_strobe && !$past(receiver_reset_line) |->
        $stable(first_shift_reg))
        else $error("shift register moved without strobe");
    a_clear_regs: assert property (receiver_reset_line |=>
        first_shift_reg == 8'h00 && !char_complete)
        else $error("receiver clear ignored");
    a_buf_holds: assert property (!rx_buffer_load |->
        $stable(rx_buffer) || rx_buffer == 12'h000)
        else $error("buffer changed without load or clear");
    a_load_follows: assert property (rx_buffer_load && !rx_buffer[9] |->
        since_cc <= 4'hC)
        else $error("load without a completed character");
    a_crc_status: assert property (rx_buffer_load |-> rx_buffer[8] == $past(crc_ok))
        else $error("crc status not captured");
    a_idle_quiet: assert property ($stable(rx_clk) [*8] |=>
        !crc_strobe && !char_complete)
        else $error("strobe without receive clock");

    c_complete: cover property (char_complete);
    c_load_end: cover property (rx_buffer_load && rx_buffer[9]);
    c_load_data: cover property (rx_buffer_load && !rx_buffer[9]);
endmodule

bind scca_receiver scca_monitor u_scca_monitor (.mclk(mclk), .rst_n(rst_n), .rx_clk(rx_clk),
    .receiver_reset_line(receiver_reset_line), .crc_ok(crc_ok),
    .first_shift_reg(first_shift_reg), .char_complete(char_complete), .crc_bit(crc_bit),
    .crc_strobe(crc_strobe), .rx_buffer(rx_buffer), .rx_buffer_load(rx_buffer_load));

// *** test/tb.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("Error at %0t: got %h exp %h", $time, g, e); \
    end \
end

module tb;
    logic mclk, rst_n, rx_clk, rx_data, receiver_reset_line, sec_mode, crc_ok;
    logic [7:0] sync_value;
    logic [7:0] first_shift_reg;
    logic char_complete, crc_bit, crc_strobe, rx_buffer_load;
    logic [11:0] rx_buffer;
    logic [11:0] want;
    logic [11:0] expq[$];
    logic [31:0] rng = 32'h49;
    bit fresh;
    int failures, check_count, cycles;

    scca_receiver u_scca_receiver (.mclk(mclk), .rst_n(rst_n), .rx_clk(rx_clk),
        .rx_data(rx_data), .receiver_reset_line(receiver_reset_line), .sec_mode(sec_mode),
        .sync_value(sync_value), .crc_ok(crc_ok), .first_shift_reg(first_shift_reg),
        .char_complete(char_complete), .crc_bit(crc_bit), .crc_strobe(crc_strobe),
        .rx_buffer(rx_buffer), .rx_buffer_load(rx_buffer_load));
    scca_modem u_scca_modem (.rx_clk(rx_clk), .rx_data(rx_data));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [11:0] ebuf(input logic [7:0] c, input logic e, input logic k);
        return {2'h0, e, k, c};
    endfunction

    task automatic complete_run();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // each load must be the next expected character, in order
    always @(negedge mclk) begin
        if (rst_n === 1'b1 && rx_buffer_load === 1'b1) begin
            `CHK(expq.size() > 0, 1'b1)
            if (expq.size() > 0) begin
                want = expq.pop_front();
                `CHK(rx_buffer, want)
            end
        end
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            $display("Error at %0t: timeout", $time);
            complete_run();
        end
    end

    // mode 0 primary, 1 address hit, 2 address miss, 3 abort, 4 receiver clear
    task automatic frame(input int n, input logic [7:0] c0, input int mode);
        logic [7:0] c;
        logic [7:0] prev;
        logic [7:0] pp;
        tick(1);
        // qualified character ahead of the first one is the opening flag
        pp = 8'h7E;
        rng = xs(rng);
        crc_ok = rng[0];
        sec_mode = (mode == 1 || mode == 2);
        // a repeated opening flag: only the last one counts
        if (mode == 0) u_scca_modem.send_flag();
        u_scca_modem.send_flag();
        if (fresh) begin
            tick(12);
            `CHK(rx_buffer, 12'h000)
        end
        if (mode == 1 || mode == 2) u_scca_modem.send_byte(mode == 1 ? sync_value : ~sync_value, 1);
        for (int i = 0; i < n; i++) begin
            rng = xs(rng);
            c = (i == 0) ? c0 : rng[15:8];
            if (i > 0 && mode != 2) expq.push_back(ebuf(prev, 1'b0, crc_ok));
            u_scca_modem.send_byte(c, 1'b1);
            if (i > 0) pp = prev;
            prev = c;
        end
        tick(6);
        if (mode != 2) `CHK(first_shift_reg, c)
        if (mode == 4) begin
            receiver_reset_line = 1'b1;
            tick(1);
            receiver_reset_line = 1'b0;
            tick(1);
            `CHK(first_shift_reg, 8'h00)
        end else begin
            // abort lands after 7 - t more shifts, t being the ones already trailing
            if (mode == 3) expq.push_back(ebuf(8'({prev, pp} >> (7 - u_scca_modem.ones)),
                1'b1, crc_ok));
            else if (mode != 2) expq.push_back(ebuf(prev, 1'b1, crc_ok));
            if (mode == 3) repeat (7) u_scca_modem.send_bit(1'b1);
            else u_scca_modem.send_flag();
        end
        fresh = (mode >= 3);
        u_scca_modem.idle();
        for (int w = 0; w < 100 && expq.size() > 0; w++) tick(1);
        `CHK(expq.size(), 0)
        $display("frame mode %0d done", mode);
    endtask

    initial begin
        rst_n = 1'b0;
        receiver_reset_line = 1'b0;
        sec_mode = 1'b0;
        crc_ok = 1'b0;
        sync_value = 8'h00;
        fork
            u_scca_modem.send_bit(1'b1);
        join_none
        tick(6);
        rst_n = 1'b1;
        rng = xs(rng);
        sync_value = rng[7:0];
        tick(4);
        // clocked marks before any zero must not disturb framing
        repeat (9) u_scca_modem.send_bit(1'b1);
        frame(3, 8'hFF, 0);
        frame(4, 8'h7E, 0);
        frame(2, 8'h1F, 3);
        frame(3, 8'h00, 1);
        frame(2, 8'hF8, 2);
        frame(2, 8'hA5, 4);
        for (int k = 0; k < 8; k++) begin
            rng = xs(rng);
            u_scca_modem.slow = k[0] ? 20 : 0;
            frame(1 + int'(rng[2:0]), rng[15:8], int'(rng[17:16]));
        end
        complete_run();
    end
endmodule

// *** verilog/scca_receiver.sv ***
`timescale 1ns/1ns
`include "scca_map.svh"

// What this block does
// - until the first sampled zero, first-zero latch and ones-run counter stay cleared while line idles marking
// - first sampled zero sets first-zero latch until init or receiver clear
// - once latched, ones-run counter clears at mid-bit pulse of every zero bit
// - ones-run counter is 8-bit shift of ones; finds flags and stuffed zeros
// - character bit counter counts data bits, skips stuffed zeros, flags completion
// - bit counter is one-hot ring, held at top while not framed
// - data character complete needs counter at last (8'h40), framed and shift enable together
// - bit counter advances only on qualified bit clock; stuffed zeros withheld
// - a flag frames the receiver and completes, but is never loaded
// - primary delivers after last opening flag; secondary after matched address
// - eighth bit of a data character loads the receive buffer for the silo
// - serial data enters first shift register, compared against sync value
// - bit 0 of first register feeds extended register and CRC checker
// - both shift registers shift on qualified bit clock, clear on reset/clear
// - receive buffer is 12 bits: character plus four status bits
// - buffer captures on load request, delayed active and mid-bit pulse together
// - buffer clears when the receiver becomes framed
// - seven consecutive ones abort and clear the receive control state
// - each receive clock gives a bit pulse on rise, mid-bit pulse on fall

module scca_receiver (
    // core clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // link from modem
    input wire logic rx_clk,
    input wire logic rx_data,
    // control and configuration
    input wire logic receiver_reset_line,
    input wire logic sec_mode,
    input wire logic [7:0] sync_value,
    input wire logic crc_ok,
    // character assembly state
    output logic [7:0] first_shift_reg,
    output logic char_complete,
    // crc checker feed
    output logic crc_bit,
    output logic crc_strobe,
    // receive buffer toward the silo
    output logic [11:0] rx_buffer,
    output logic rx_buffer_load
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // exactly idx+1 consecutive ones seen so far
    function automatic logic run_exact(input logic [7:0] run, input int idx);
        run_exact = run[idx] & ~run[idx + 1];
    endfunction

    // ----------------------------------------------------------------
    // link domain: sample data on the rising receive clock
    // ----------------------------------------------------------------
    logic link_bit;
    logic link_tog;
    logic next_link_bit;
    logic next_link_tog;

    always_comb begin
        next_link_bit = rx_data;
        next_link_tog = ~link_tog;
    end

    always_ff @(posedge rx_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_bit <= 1'b1;
            link_tog <= 1'b0;
        end else begin
            link_bit <= next_link_bit;
            link_tog <= next_link_tog;
        end
    end

    // ----------------------------------------------------------------
    // crossing: toggle for the rising edge, clock level for the falling
    // ----------------------------------------------------------------
    // data bit travels beside the toggle; it is stable a whole bit time
    logic tog_s1, tog_s2, tog_s3;
    logic ck_s1, ck_s2, ck_s3;
    logic dat_s1, dat_s2;
    logic bit_clock_pulse;
    logic mid_bit_pulse;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            ck_s1 <= 1'b0;
            ck_s2 <= 1'b0;
            ck_s3 <= 1'b0;
            dat_s1 <= 1'b1;
            dat_s2 <= 1'b1;
        end else begin
            tog_s1 <= link_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            ck_s1 <= rx_clk;
            ck_s2 <= ck_s1;
            ck_s3 <= ck_s2;
            dat_s1 <= link_bit;
            dat_s2 <= dat_s1;
        end
    end

    // single-cycle strobes replace the one-shot pulses
    assign bit_clock_pulse = tog_s2 ^ tog_s3;
    assign mid_bit_pulse = ck_s3 & ~ck_s2;

    // ----------------------------------------------------------------
    // receive core state
    // ----------------------------------------------------------------
    logic first_zero_latch, next_first_zero_latch;
    logic [7:0] ones_run_counter, next_ones_run_counter;
    logic [7:0] char_bit_counter, next_char_bit_counter;
    logic [7:0] ext_shift_reg, next_ext_shift_reg;
    logic [7:0] next_first_shift_reg;
    scca_pkg::scca_rcs_e receive_control_state, next_rcs;
    logic primed, next_primed;
    logic load_req, next_load_req;
    logic load_end, next_load_end;
    logic delayed_active, next_delayed_active;
    logic framed_q, next_framed_q;
    logic next_char_complete;
    logic next_crc_bit, next_crc_strobe;
    logic [11:0] next_rx_buffer;
    logic next_rx_buffer_load;

    logic d;
    logic framed;
    logic stuffed;
    logic flag;
    logic abort;
    logic shift_enable;
    logic cmpl;

    always_comb begin
        d = dat_s2;
        framed = (receive_control_state != scca_pkg::SCCA_INACT);
        stuffed = first_zero_latch & ~d & run_exact(ones_run_counter, `SCCA_RUN_STUFF);
        flag = first_zero_latch & ~d & run_exact(ones_run_counter, `SCCA_RUN_FLAG);
        // sixth one already held and a seventh arriving
        abort = first_zero_latch & d & ones_run_counter[`SCCA_RUN_FLAG];
        shift_enable = bit_clock_pulse & ~stuffed;
        cmpl = framed & shift_enable & (char_bit_counter == `SCCA_CTR_LAST);

        next_first_zero_latch = first_zero_latch;
        next_ones_run_counter = ones_run_counter;
        next_char_bit_counter = char_bit_counter;
        next_first_shift_reg = first_shift_reg;
        next_ext_shift_reg = ext_shift_reg;
        next_rcs = receive_control_state;
        next_primed = primed;
        next_load_req = load_req;
        next_load_end = load_end;
        next_delayed_active = delayed_active;
        next_framed_q = framed;
        next_char_complete = 1'b0;
        next_crc_bit = crc_bit;
        next_crc_strobe = shift_enable;
        next_rx_buffer = rx_buffer;
        next_rx_buffer_load = 1'b0;

        // first zero out of marking arms the ones counter
        if (bit_clock_pulse && !d) begin
            next_first_zero_latch = 1'b1;
        end
        if (!first_zero_latch) begin
            next_ones_run_counter = `SCCA_CHAR_CLR;
        end else if (bit_clock_pulse) begin
            next_ones_run_counter = {ones_run_counter[6:0], d};
        end else if (mid_bit_pulse && !ones_run_counter[0]) begin
            next_ones_run_counter = `SCCA_CHAR_CLR;
        end

        // shift registers; stuffed zeros never enter
        if (shift_enable) begin
            next_first_shift_reg = {d, first_shift_reg[7:1]};
            next_ext_shift_reg = {first_shift_reg[0], ext_shift_reg[7:1]};
            next_crc_bit = first_shift_reg[0];
        end

        // one-hot ring, parked at the top while unframed
        if (!framed) begin
            next_char_bit_counter = `SCCA_CTR_TOP;
        end else if (shift_enable) begin
            next_char_bit_counter = {char_bit_counter[6:0], char_bit_counter[7]};
        end

        // receive control decisions on each bit
        if (bit_clock_pulse) begin
            if (abort) begin
                next_rcs = scca_pkg::SCCA_INACT;
                next_primed = 1'b0;
                next_char_bit_counter = `SCCA_CTR_TOP;
                if (receive_control_state == scca_pkg::SCCA_ACTIVE && primed) begin
                    next_load_req = 1'b1;
                    next_load_end = 1'b1;
                end
            end else if (flag) begin
                next_char_complete = 1'b1;
                next_char_bit_counter = `SCCA_CTR_TOP;
                // a closing flag delivers the character still held back
                if (receive_control_state == scca_pkg::SCCA_ACTIVE && primed) begin
                    next_load_req = 1'b1;
                    next_load_end = 1'b1;
                end
                next_primed = 1'b0;
                next_rcs = sec_mode ? scca_pkg::SCCA_ADDR : scca_pkg::SCCA_ACTIVE;
            end else if (cmpl) begin
                next_char_complete = 1'b1;
                unique case (receive_control_state)
                    scca_pkg::SCCA_INACT: begin
                        next_rcs = receive_control_state;
                    end
                    scca_pkg::SCCA_ADDR: begin
                        next_rcs = (next_first_shift_reg == sync_value) ?
                            scca_pkg::SCCA_ACTIVE : scca_pkg::SCCA_WAIT;
                    end
                    scca_pkg::SCCA_ACTIVE: begin
                        // extended register lags a character; first one is the flag, or the address in secondary
                        if (primed) begin
                            next_load_req = 1'b1;
                            next_load_end = 1'b0;
                        end
                        next_primed = 1'b1;
                    end
                    scca_pkg::SCCA_WAIT: begin
                        next_rcs = receive_control_state;
                    end
                endcase
            end
        end

        // buffer capture at mid-bit, one bit after active
        if (mid_bit_pulse) begin
            if (load_req && delayed_active) begin
                next_rx_buffer = {`SCCA_STAT_RSVD, load_end, crc_ok, ext_shift_reg};
                next_rx_buffer_load = 1'b1;
            end
            next_load_req = 1'b0;
            next_delayed_active = (receive_control_state == scca_pkg::SCCA_ACTIVE);
        end

        // becoming framed empties the buffer
        if (framed && !framed_q) begin
            next_rx_buffer = `SCCA_BUF_CLR;
        end

        // software clear of the receiver section
        if (receiver_reset_line) begin
            next_first_zero_latch = 1'b0;
            next_ones_run_counter = `SCCA_CHAR_CLR;
            next_char_bit_counter = `SCCA_CTR_TOP;
            next_first_shift_reg = `SCCA_CHAR_CLR;
            next_ext_shift_reg = `SCCA_CHAR_CLR;
            next_rcs = scca_pkg::SCCA_INACT;
            next_primed = 1'b0;
            next_load_req = 1'b0;
            next_load_end = 1'b0;
            next_delayed_active = 1'b0;
            next_char_complete = 1'b0;
            next_crc_strobe = 1'b0;
            next_rx_buffer_load = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            first_zero_latch <= 1'b0;
            ones_run_counter <= `SCCA_CHAR_CLR;
            char_bit_counter <= `SCCA_CTR_TOP;
            first_shift_reg <= `SCCA_CHAR_CLR;
            ext_shift_reg <= `SCCA_CHAR_CLR;
            receive_control_state <= scca_pkg::SCCA_INACT;
            primed <= 1'b0;
            load_req <= 1'b0;
            load_end <= 1'b0;
            delayed_active <= 1'b0;
            framed_q <= 1'b0;
            char_complete <= 1'b0;
            crc_bit <= 1'b0;
            crc_strobe <= 1'b0;
            rx_buffer <= `SCCA_BUF_CLR;
            rx_buffer_load <= 1'b0;
        end else begin
            first_zero_latch <= next_first_zero_latch;
            ones_run_counter <= next_ones_run_counter;
            char_bit_counter <= next_char_bit_counter;
            first_shift_reg <= next_first_shift_reg;
            ext_shift_reg <= next_ext_shift_reg;
            receive_control_state <= next_rcs;
            primed <= next_primed;
            load_req <= next_load_req;
            load_end <= next_load_end;
            delayed_active <= next_delayed_active;
            framed_q <= next_framed_q;
            char_complete <= next_char_complete;
            crc_bit <= next_crc_bit;
            crc_strobe <= next_crc_strobe;
            rx_buffer <= next_rx_buffer;
            rx_buffer_load <= next_rx_buffer_load;
        end
    end

endmodule
